// ### hw/spdc_consts.svh
// Purpose: Constants for the setpoint detect and compare unit
// Assumes: 16-bit samples, sixteen setpoints
// Notes:   Included by bare name
`ifndef SPDC_CONSTS_SVH
`define SPDC_CONSTS_SVH

`define SPDC_NUM_SP      16
`define SPDC_DATA_W      16
`define SPDC_IDX_W       4
`define SPDC_PORT_W      8
`define SPDC_NUM_DAC     4
`define SPDC_NUM_TMR     4
`define SPDC_DAC_SEL_W   2
// Criterion codes
`define SPDC_CRIT_INSIDE  3'h0
`define SPDC_CRIT_OUTSIDE 3'h1
`define SPDC_CRIT_GT      3'h2
`define SPDC_CRIT_LT      3'h3
`define SPDC_CRIT_EQ      3'h4
`define SPDC_CRIT_HYST    3'h5
// Target codes
`define SPDC_TGT_NONE     2'h0
`define SPDC_TGT_PORT     2'h1
`define SPDC_TGT_DAC      2'h2
`define SPDC_TGT_TIMER    2'h3
// Reset values
`define SPDC_FLAGS_RST    16'h0000
`define SPDC_PORT_RST     8'h00

`endif

// ### hw/spdc_pkg.sv
// Purpose: Types for the setpoint detect and compare unit
// Assumes: Constants header is on the include path
// Notes:   Types only
`include "spdc_consts.svh"

package spdc_pkg;

  typedef logic [`SPDC_DATA_W-1:0] spdc_word_t;
  typedef logic [`SPDC_IDX_W-1:0]  spdc_idx_t;

  typedef enum logic [2:0] {
    SPDC_IDLE  = 3'b001,
    SPDC_ARMED = 3'b010,
    SPDC_RUN   = 3'b100
  } spdc_state_e;

endpackage : spdc_pkg

// ### hw/spdc_compare.sv
// Purpose: One setpoint comparator with hysteresis state
// Assumes: Limits and criterion stable while running
// Notes:   Sample is unsigned 16 bits
`timescale 1ns/1ps
`default_nettype none
`include "spdc_consts.svh"

module spdc_compare
  import spdc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_clear,
  input  wire logic       i_eval,
  input  wire spdc_word_t i_sample,
  input  wire spdc_word_t i_limit_hi,
  input  wire spdc_word_t i_limit_lo,
  input  wire logic [2:0] i_crit,
  output logic            o_true,
  output logic            o_hyst_hi,
  output logic            o_hyst_move
);

  wire above_hi = i_sample > i_limit_hi;
  wire below_hi = i_sample < i_limit_hi;
  wire above_lo = i_sample > i_limit_lo;
  wire below_lo = i_sample < i_limit_lo;
  wire is_hyst  = i_crit == `SPDC_CRIT_HYST;

  logic hyst_hi;
  logic crit_met;

  always_comb begin
    case (i_crit)
      `SPDC_CRIT_INSIDE:  crit_met = below_hi && above_lo; // R3
      `SPDC_CRIT_OUTSIDE: crit_met = above_hi || below_lo; // R4
      `SPDC_CRIT_GT:      crit_met = above_lo; // R5
      `SPDC_CRIT_LT:      crit_met = below_hi; // R6
      `SPDC_CRIT_EQ:      crit_met = i_sample == i_limit_hi; // R7
      `SPDC_CRIT_HYST:    crit_met = above_hi ? 1'b1 : (below_lo ? 1'b0 : hyst_hi);
      default:            crit_met = 1'b0;
    endcase
  end

  // Hysteresis latch: high once above, low once below, held inside window
  wire next_hyst_hi = above_hi ? 1'b1 : (below_lo ? 1'b0 : hyst_hi); // R9 R10

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hyst_hi <= 1'b0;
    end else if (i_clear) begin
      hyst_hi <= 1'b0;
    end else if (i_eval && is_hyst) begin
      hyst_hi <= next_hyst_hi;
    end
  end

  assign o_true      = crit_met;
  assign o_hyst_hi   = above_hi;
  assign o_hyst_move = is_hyst && (above_hi || below_lo);

endmodule : spdc_compare

`default_nettype wire

// ### hw/spdc_top.sv
// Purpose: Setpoint detection on the scan stream driving port, DAC and timer updates
// Assumes: Configuration loaded before arming; one sample per valid strobe
// Notes:   Evaluation once per scan sample of the owning channel
//
// Summary of operation
// R1: Upper and lower 16-bit limit per setpoint
// R2: Host loads configuration before acquisition runs
// R3: Inside: below upper and above lower
// R4: Outside: above upper or below lower
// R5: Greater: above lower, upper ignored
// R6: Less: below upper, lower ignored
// R7: Equal: matches upper exactly
// R8: Host uses equality only for counters
// R9: Hysteresis: above upper forces second value
// R10: Hysteresis: below lower forces first value
// R11: True writes first value to target
// R12: True-and-false mode writes second value
// R13: True-only mode leaves target unchanged
// R14: Third digital port starts as input
// R15: Evaluation starts at arm for soft triggers
// R16: Status word bit n is setpoint n
// R17: Status bit shows criterion currently met
// R18: Host places status word last in scan
// R19: One setpoint per channel, sixteen maximum
// R20: Each setpoint evaluated once per scan
// R21: Port byte with mask per setpoint
`timescale 1ns/1ps
`default_nettype none
`include "spdc_consts.svh"

module spdc_top
  import spdc_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // Configuration port, used only while idle
  input  wire logic                    i_cfg_we,
  input  wire spdc_idx_t               i_cfg_sel,
  input  wire logic                    i_cfg_en,
  input  wire spdc_word_t              i_cfg_limit_hi,
  input  wire spdc_word_t              i_cfg_limit_lo,
  input  wire logic [2:0]              i_cfg_crit,
  input  wire logic [1:0]              i_cfg_target,
  input  wire logic [1:0]              i_cfg_unit,
  input  wire logic                    i_cfg_true_false,
  input  wire spdc_word_t              i_cfg_value1,
  input  wire spdc_word_t              i_cfg_value2,
  input  wire logic [7:0]              i_cfg_mask,
  input  wire logic [7:0]              i_cfg_channel,
  // Third digital port direction control
  input  wire logic                    i_port_dir_we,
  input  wire logic                    i_port_dir_out,
  input  wire logic [7:0]              i_port_init,
  // Acquisition control
  input  wire logic                    i_arm,
  input  wire logic                    i_hw_trigger_mode,
  input  wire logic                    i_trigger,
  input  wire logic                    i_stop,
  // Scan stream
  input  wire logic                    i_smp_valid,
  input  wire logic [7:0]              i_smp_channel,
  input  wire spdc_word_t              i_smp_data,
  input  wire logic                    i_scan_end,
  // Outputs
  output logic [7:0]                   o_third_digital_port,
  output logic [7:0]                   o_third_digital_port_oe,
  output logic                         o_dac_we,
  output logic [1:0]                   o_dac_sel,
  output spdc_word_t                   o_dac_value,
  output logic                         o_timer_we,
  output logic [1:0]                   o_timer_sel,
  output spdc_word_t                   o_timer_value,
  output spdc_word_t                   o_setpoint_condition_flags,
  output spdc_word_t                   o_detect,
  output logic                         o_running
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  // Only the second flop is read by the rest of the design
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ****************************************************************
  // Run control
  // ****************************************************************
  // Hardware trigger modes wait in ARMED for the trigger
  spdc_state_e state;
  spdc_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      SPDC_IDLE:  if (i_arm) next_state = i_hw_trigger_mode ? SPDC_ARMED : SPDC_RUN; // R15
      SPDC_ARMED: if (i_stop) next_state = SPDC_IDLE;
                  else if (i_trigger) next_state = SPDC_RUN;
      SPDC_RUN:   if (i_stop) next_state = SPDC_IDLE;
      default:    next_state = SPDC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SPDC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  wire running  = state == SPDC_RUN;
  wire arm_edge = (state == SPDC_IDLE) && i_arm;
  wire cfg_ok   = i_cfg_we && (state == SPDC_IDLE); // R2

  // ****************************************************************
  // Setpoint table and comparators
  // ****************************************************************
  spdc_word_t limit_hi [`SPDC_NUM_SP];
  spdc_word_t limit_lo [`SPDC_NUM_SP];
  spdc_word_t value1   [`SPDC_NUM_SP];
  spdc_word_t value2   [`SPDC_NUM_SP];
  logic [2:0] crit     [`SPDC_NUM_SP];
  logic [1:0] target   [`SPDC_NUM_SP];
  logic [1:0] unit     [`SPDC_NUM_SP];
  logic [7:0] mask     [`SPDC_NUM_SP];
  logic [7:0] chan     [`SPDC_NUM_SP];
  logic [`SPDC_NUM_SP-1:0] sp_en;
  logic [`SPDC_NUM_SP-1:0] true_false;
  logic [`SPDC_NUM_SP-1:0] hit;
  logic [`SPDC_NUM_SP-1:0] met;
  logic [`SPDC_NUM_SP-1:0] hyst_hi;
  logic [`SPDC_NUM_SP-1:0] hyst_move;
  logic [`SPDC_NUM_SP-1:0] dup;
  logic [`SPDC_NUM_SP-1:0] want_upd;
  spdc_word_t flags;

  genvar g;
  generate
    for (g = 0; g < `SPDC_NUM_SP; g++) begin : g_sp
      // Refuse a second setpoint on a channel already owned
      logic [`SPDC_NUM_SP-1:0] same;
      for (genvar k = 0; k < `SPDC_NUM_SP; k++) begin : g_dup
        assign same[k] = (k != g) && sp_en[k] && (chan[k] == i_cfg_channel);
      end
      assign dup[g] = |same; // R19

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          sp_en[g]      <= 1'b0;
          limit_hi[g]   <= 16'h0000;
          limit_lo[g]   <= 16'h0000;
          value1[g]     <= 16'h0000;
          value2[g]     <= 16'h0000;
          crit[g]       <= `SPDC_CRIT_INSIDE;
          target[g]     <= `SPDC_TGT_NONE;
          unit[g]       <= 2'h0;
          mask[g]       <= 8'h00;
          chan[g]       <= 8'h00;
          true_false[g] <= 1'b0;
        end else if (cfg_ok && (i_cfg_sel == spdc_idx_t'(g))) begin
          sp_en[g]      <= i_cfg_en && !dup[g]; // R19
          limit_hi[g]   <= i_cfg_limit_hi; // R1
          limit_lo[g]   <= i_cfg_limit_lo; // R1
          value1[g]     <= i_cfg_value1;
          value2[g]     <= i_cfg_value2;
          crit[g]       <= i_cfg_crit;
          target[g]     <= i_cfg_target;
          unit[g]       <= i_cfg_unit;
          mask[g]       <= i_cfg_mask; // R21
          chan[g]       <= i_cfg_channel;
          true_false[g] <= i_cfg_true_false;
        end
      end

      // One evaluation per scan, on the owning channel's sample
      assign hit[g] = running && i_smp_valid && sp_en[g] && (i_smp_channel == chan[g]); // R20

      // Hysteresis updates on every sample outside the window; others per update mode
      assign want_upd[g] = hit[g] && ((crit[g] == `SPDC_CRIT_HYST) ? hyst_move[g]
                                      : (met[g] || true_false[g])); // R12 R13

      spdc_compare u_cmp (
        .i_clk       (i_clk),
        .i_rst_n     (rst_n),
        .i_clear     (arm_edge),
        .i_eval      (hit[g]),
        .i_sample    (i_smp_data),
        .i_limit_hi  (limit_hi[g]),
        .i_limit_lo  (limit_lo[g]),
        .i_crit      (crit[g]),
        .o_true      (met[g]),
        .o_hyst_hi   (hyst_hi[g]),
        .o_hyst_move (hyst_move[g])
      );

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[g] <= 1'b0;
        end else if (arm_edge) begin
          flags[g] <= 1'b0;
        end else if (hit[g]) begin
          flags[g] <= met[g]; // R16 R17
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Output update selection
  // ****************************************************************
  // At most one sample per cycle, so at most one setpoint fires; lowest index wins
  logic       upd;
  spdc_idx_t  upd_idx;

  always_comb begin
    upd     = 1'b0;
    upd_idx = '0;
    for (int i = `SPDC_NUM_SP - 1; i >= 0; i--) begin
      if (want_upd[i]) begin
        upd     = 1'b1;
        upd_idx = spdc_idx_t'(i);
      end
    end
  end

  wire        sel_hyst  = crit[upd_idx] == `SPDC_CRIT_HYST;
  wire        use_two   = sel_hyst ? hyst_hi[upd_idx] : !met[upd_idx]; // R9 R10 R12
  wire [15:0] upd_value = use_two ? value2[upd_idx] : value1[upd_idx]; // R11
  wire [1:0]  upd_tgt   = upd ? target[upd_idx] : `SPDC_TGT_NONE;
  wire [7:0]  upd_mask  = mask[upd_idx];
  wire [7:0]  next_port = (o_third_digital_port & ~upd_mask) | (upd_value[7:0] & upd_mask);
  wire        upd_port  = upd_tgt == `SPDC_TGT_PORT;
  wire        upd_dac   = upd_tgt == `SPDC_TGT_DAC;
  wire        upd_timer = upd_tgt == `SPDC_TGT_TIMER;

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Direction load is taken only while not running; setpoint updates win during a run
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_third_digital_port    <= `SPDC_PORT_RST;
      o_third_digital_port_oe <= 8'h00; // R14
    end else if (i_port_dir_we && !running) begin
      o_third_digital_port    <= i_port_init;
      o_third_digital_port_oe <= {8{i_port_dir_out}};
    end else if (upd_port) begin
      o_third_digital_port    <= next_port; // R21
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_dac_we      <= 1'b0;
      o_dac_sel     <= 2'h0;
      o_dac_value   <= 16'h0000;
      o_timer_we    <= 1'b0;
      o_timer_sel   <= 2'h0;
      o_timer_value <= 16'h0000;
    end else begin
      o_dac_we   <= upd_dac; // R11
      o_timer_we <= upd_timer; // R11
      if (upd_dac) begin
        o_dac_sel   <= unit[upd_idx];
        o_dac_value <= upd_value;
      end
      if (upd_timer) begin
        o_timer_sel   <= unit[upd_idx];
        o_timer_value <= upd_value;
      end
    end
  end

  // ****************************************************************
  // Status word
  // ****************************************************************
  // Status word is sampled into the scan at scan end, so it belongs last
  spdc_word_t detect_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      detect_q <= `SPDC_FLAGS_RST;
    end else if (i_scan_end) begin
      detect_q <= flags; // R18
    end
  end

  assign o_setpoint_condition_flags = flags; // R16
  assign o_detect                   = detect_q;
  assign o_running                  = running;

endmodule : spdc_top

`default_nettype wire

// ### tb/spdc_top_assertions.sv
// Purpose: Port-level checks for the setpoint detect unit
// Assumes: Bound to spdc_top, one clock domain
// Notes:   Reset disables every check
`timescale 1ns/1ps
`default_nettype none

module spdc_top_chk
  import spdc_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_arm,
  input wire logic       i_hw_trigger_mode,
  input wire logic       i_stop,
  input wire logic       i_smp_valid,
  input wire logic       i_scan_end,
  input wire logic       i_port_dir_we,
  input wire logic       o_dac_we,
  input wire logic       o_timer_we,
  input wire logic [7:0] o_third_digital_port,
  input wire logic [7:0] o_third_digital_port_oe,
  input wire spdc_word_t o_setpoint_condition_flags,
  input wire spdc_word_t o_detect,
  input wire logic       o_running
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_arm_clr;
    i_arm && !o_running |=> o_setpoint_condition_flags == 16'h0000;
  endproperty
  a_arm_clr: assert property (p_arm_clr) else $error("flags kept at arm");
  property p_soft_run;
    i_arm && !o_running && !i_hw_trigger_mode && !i_stop |=> o_running;
  endproperty
  a_soft_run: assert property (p_soft_run) else $error("soft arm not running");
  property p_flag_cause;
    $changed(o_setpoint_condition_flags) |-> $past(i_smp_valid) || $past(i_arm);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flags moved alone");
  property p_detect;
    o_running && i_scan_end |=> o_detect == $past(o_setpoint_condition_flags);
  endproperty
  a_detect: assert property (p_detect) else $error("detect not captured");
  property p_detect_hold;
    o_running && !i_scan_end |=> $stable(o_detect);
  endproperty
  a_detect_hold: assert property (p_detect_hold) else $error("detect moved mid scan");
  property p_cause;
    o_dac_we || o_timer_we |-> $past(i_smp_valid) && $past(o_running);
  endproperty
  a_cause: assert property (p_cause) else $error("update without sample");
  property p_port_idle;
    !o_running && !i_port_dir_we |=> $stable(o_third_digital_port);
  endproperty
  a_port_idle: assert property (p_port_idle) else $error("port moved idle");
  property p_oe;
    $changed(o_third_digital_port_oe) |-> $past(i_port_dir_we) && !$past(o_running);
  endproperty
  a_oe: assert property (p_oe) else $error("port direction moved");
endmodule : spdc_top_chk

bind spdc_top spdc_top_chk spdc_top_chk_inst (.i_clk, .i_rst_n, .i_arm, .i_hw_trigger_mode,
  .i_stop, .i_smp_valid, .i_scan_end, .i_port_dir_we, .o_dac_we, .o_timer_we,
  .o_third_digital_port, .o_third_digital_port_oe, .o_setpoint_condition_flags,
  .o_detect, .o_running);

`default_nettype wire

// ### tb/spdc_scan_seq.sv
// Purpose: Scan sequencer model feeding samples
// Assumes: One sample per scan, status word last
// Notes:   Released lines show inverted data
`timescale 1ns/1ps
`default_nettype none

module spdc_scan_seq
  import spdc_pkg::*;
(
  input  wire logic i_clk,
  output logic      o_smp_valid,
  output logic [7:0] o_smp_channel,
  output spdc_word_t o_smp_data,
  output logic      o_scan_end
);
  initial begin
    o_smp_valid = 1'h0;
    o_smp_channel = 8'h00;
    o_smp_data = 16'h0000;
    o_scan_end = 1'h0;
  end

  // One scan, gap cycles before the status word
  task automatic send(input logic [7:0] ch, input spdc_word_t d, input int gap);
    @(posedge i_clk);
    #1 o_smp_valid = 1'h1;
    o_smp_channel = ch;
    o_smp_data = d;
    @(posedge i_clk);
    #1 o_smp_valid = 1'h0;
    o_smp_channel = ~ch;
    o_smp_data = ~d;
    repeat (gap) @(posedge i_clk);
    #1 o_scan_end = 1'h1;
    @(posedge i_clk);
    #1 o_scan_end = 1'h0;
  endtask : send
endmodule : spdc_scan_seq

`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the setpoint detect unit
// Assumes: One-cycle answer latency
// Notes:   Criterion table first, then hand tests
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import spdc_pkg::*;
;
  typedef struct packed {
    logic [2:0] crit; logic tf; spdc_word_t d; logic fl; logic we; spdc_word_t val;
  } spdc_row_s;
  logic i_clk, i_rst_n, i_cfg_we, i_cfg_en, i_cfg_true_false, i_port_dir_we, i_port_dir_out;
  logic i_arm, i_hw_trigger_mode, i_trigger, i_stop, i_smp_valid, i_scan_end;
  logic o_dac_we, o_timer_we, o_running, got_dac;
  spdc_idx_t  i_cfg_sel;
  spdc_word_t i_cfg_limit_hi, i_cfg_limit_lo, i_cfg_value1, i_cfg_value2, i_smp_data, got_val;
  spdc_word_t o_dac_value, o_timer_value, o_setpoint_condition_flags, o_detect;
  logic [2:0] i_cfg_crit;
  logic [1:0] i_cfg_target, i_cfg_unit, o_dac_sel, o_timer_sel, got_sel;
  logic [7:0] i_cfg_mask, i_cfg_channel, i_port_init, i_smp_channel;
  logic [7:0] o_third_digital_port, o_third_digital_port_oe;
  int         err_count = 0;
  int         total_checks = 0;
  int         upd_count = 0;
  spdc_row_s  rows [15] = '{
    '{3'h0, 1'h1, 16'h0800, 1'h1, 1'h1, 16'h1111},
    '{3'h0, 1'h1, 16'h1000, 1'h0, 1'h1, 16'h2222},
    '{3'h0, 1'h0, 16'h0100, 1'h0, 1'h0, 16'h0000},
    '{3'h1, 1'h1, 16'h1001, 1'h1, 1'h1, 16'h1111},
    '{3'h1, 1'h1, 16'h00FF, 1'h1, 1'h1, 16'h1111},
    '{3'h1, 1'h1, 16'h0FFF, 1'h0, 1'h1, 16'h2222},
    '{3'h2, 1'h1, 16'h2000, 1'h1, 1'h1, 16'h1111},
    '{3'h2, 1'h1, 16'h0100, 1'h0, 1'h1, 16'h2222},
    '{3'h3, 1'h1, 16'h0050, 1'h1, 1'h1, 16'h1111},
    '{3'h3, 1'h0, 16'h1000, 1'h0, 1'h0, 16'h0000},
    '{3'h4, 1'h1, 16'h1000, 1'h1, 1'h1, 16'h1111},
    '{3'h4, 1'h1, 16'h0FFF, 1'h0, 1'h1, 16'h2222},
    '{3'h5, 1'h0, 16'h1001, 1'h1, 1'h1, 16'h2222},
    '{3'h5, 1'h0, 16'h00FF, 1'h0, 1'h1, 16'h1111},
    '{3'h5, 1'h1, 16'h0800, 1'h0, 1'h0, 16'h0000}};

  spdc_top spdc_top_inst (.*);
  spdc_scan_seq spdc_scan_seq_inst (.i_clk, .o_smp_valid(i_smp_valid),
    .o_smp_channel(i_smp_channel), .o_smp_data(i_smp_data), .o_scan_end(i_scan_end));

  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) if (o_dac_we || o_timer_we) begin
    upd_count <= upd_count + 1;
    got_dac <= o_dac_we;
    got_val <= o_dac_we ? o_dac_value : o_timer_value;
    got_sel <= o_dac_we ? o_dac_sel : o_timer_sel;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic chk(string n, spdc_word_t e, spdc_word_t g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    @(posedge i_clk);
    #1 s = 1'h1;
    @(posedge i_clk);
    #1 s = 1'h0;
  endtask : pulse

  task automatic cfg(logic [2:0] c, logic t, logic [1:0] g);
    i_cfg_crit = c;
    i_cfg_true_false = t;
    i_cfg_target = g;
    pulse(i_cfg_we);
  endtask : cfg

  task automatic step(logic [7:0] ch, spdc_word_t d, logic we, spdc_word_t v,
                      spdc_word_t fl, int gap);
    int n0;
    n0 = upd_count;
    spdc_scan_seq_inst.send(ch, d, gap);
    chk("update", {15'h0, we}, 16'(upd_count - n0));
    if (we) chk("value", v, got_val);
    chk("flags", fl, o_setpoint_condition_flags);
    chk("detect", fl, o_detect);
  endtask : step

  initial begin
    {i_rst_n, i_cfg_we, i_port_dir_we, i_port_dir_out, i_arm} = 5'h00;
    {i_hw_trigger_mode, i_trigger, i_stop, i_cfg_crit} = 6'h00;
    {i_cfg_sel, i_cfg_en, i_cfg_target, i_cfg_unit, i_cfg_true_false} = 10'h032;
    {i_cfg_limit_hi, i_cfg_limit_lo} = 32'h1000_0100;
    {i_cfg_value1, i_cfg_value2} = 32'h1111_2222;
    {i_cfg_mask, i_cfg_channel, i_port_init} = 24'h0F01_00;
    repeat (4) @(posedge i_clk);
    #1 i_rst_n = 1'h1;
    repeat (3) @(posedge i_clk);
    #1;
    chk("oe", 16'h0000, {8'h00, o_third_digital_port_oe});
    chk("running", 16'h0000, {15'h0, o_running});
    $display("test reset done");
    foreach (rows[k]) begin
      pulse(i_stop);
      cfg(rows[k].crit, rows[k].tf, 2'h2);
      pulse(i_arm);
      step(8'h01, rows[k].d, rows[k].we, rows[k].val, {15'h0, rows[k].fl}, 0);
      if (rows[k].we) chk("dac_sel", 16'h0005, {13'h0, got_dac, got_sel});
    end
    $display("test table done");
    pulse(i_stop);
    cfg(3'h5, 1'h0, 2'h2);
    pulse(i_arm);
    step(8'h01, 16'h1001, 1'h1, 16'h2222, 16'h0001, 2);
    step(8'h01, 16'h0800, 1'h0, 16'h0000, 16'h0001, 0);
    step(8'h01, 16'h00FF, 1'h1, 16'h1111, 16'h0000, 0);
    step(8'h01, 16'h1001, 1'h1, 16'h2222, 16'h0001, 0);
    $display("test hysteresis done");
    pulse(i_stop);
    i_port_dir_out = 1'h1;
    i_port_init = 8'hA5;
    pulse(i_port_dir_we);
    chk("port", 16'h00A5, {8'h00, o_third_digital_port});
    chk("oe", 16'h00FF, {8'h00, o_third_digital_port_oe});
    {i_cfg_value1, i_cfg_value2} = 32'h007C_0033;
    cfg(3'h0, 1'h1, 2'h1);
    pulse(i_arm);
    step(8'h01, 16'h0800, 1'h0, 16'h0000, 16'h0001, 0);
    chk("port", 16'h00AC, {8'h00, o_third_digital_port});
    step(8'h01, 16'h1000, 1'h0, 16'h0000, 16'h0000, 0);
    chk("port", 16'h00A3, {8'h00, o_third_digital_port});
    $display("test port done");
    pulse(i_stop);
    i_cfg_unit = 2'h3;
    cfg(3'h0, 1'h1, 2'h3);
    {i_cfg_sel, i_cfg_channel} = 12'hF02;
    cfg(3'h2, 1'h0, 2'h0);
    {i_cfg_sel, i_cfg_channel} = 12'h101;
    cfg(3'h2, 1'h0, 2'h0);
    pulse(i_arm);
    step(8'h01, 16'h0800, 1'h1, 16'h007C, 16'h0001, 0);
    chk("timer_sel", 16'h0003, {13'h0, got_dac, got_sel});
    step(8'h02, 16'h2000, 1'h0, 16'h0000, 16'h8001, 0);
    $display("test status done");
    pulse(i_stop);
    step(8'h01, 16'h1000, 1'h0, 16'h0000, 16'h8001, 0);
    i_hw_trigger_mode = 1'h1;
    pulse(i_arm);
    chk("running", 16'h0000, {15'h0, o_running});
    pulse(i_trigger);
    chk("running", 16'h0001, {15'h0, o_running});
    step(8'h01, 16'h0800, 1'h1, 16'h007C, 16'h0001, 0);
    $display("test trigger done");
    complete_run();
  end

  initial begin
    #500000;
    err_count++;
    $display("ERROR watchdog expected end seen timeout");
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
